/* File: nipu_top.sv */
// nested interrupt priority unit: register slave, arbitration, cpu level, low power
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module nipu_top
	import nipu_pkg::*;
#(
	parameter int NUM_VEC = 14
) (
	// clock, reset, enable
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	// avalon-mm slave
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// request sources
	input wire logic extReqA,
	input wire logic extReqB,
	input wire logic extReqC,
	input wire logic [1:0] extSelOption,
	input wire logic [NUM_VEC-1:0] periphReq,
	input wire logic [NUM_VEC-1:0] periphEnable,
	// cpu core events
	input wire logic instrBoundary,
	input wire logic trapExec,
	input wire logic waitExec,
	input wire logic haltExec,
	input wire logic returnExec,
	input wire logic [1:0] returnLevel,
	input wire logic ccWrite,
	input wire logic [1:0] ccWriteLevel,
	// cpu core answers
	output logic cpuPrioHigh,
	output logic cpuPrioLow,
	output logic serviceStrobe,
	output logic [15:0] serviceVector,
	output logic [3:0] serviceIndex,
	output logic [NUM_VEC-1:0] serviceAck,
	output logic cpuStopped,
	output logic haltActive,
	output logic activeHaltActive,
	// interrupt to the system
	output logic irq
);
	//--------------------------------------------------------------------------
	// helpers
	//--------------------------------------------------------------------------

	// vector address of maskable vector n
	function automatic logic [15:0] vecAddr(input logic [3:0] n);
		vecAddr = `NIPU_VEC_BASE - {11'h000, n, 1'b0};
	endfunction : vecAddr

	// index of a register from a byte address
	function automatic logic [5:0] regIdx(input logic [7:0] addr);
		regIdx = addr[7:2];
	endfunction : regIdx

	//--------------------------------------------------------------------------
	// bus slave
	//--------------------------------------------------------------------------
	logic ack_q;
	logic ack_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic wrTake;
	logic [5:0] idx;
	logic [31:0] prioFlat;
	logic discard;
	logic [`NIPU_ST_W-1:0] stat_q;
	logic [`NIPU_ST_W-1:0] stat_d;
	logic [`NIPU_ST_W-1:0] mask_q;
	logic [`NIPU_ST_W-1:0] mask_d;
	logic tbie_q;
	logic tbie_d;
	nipu_mode_e mode_q;
	nipu_mode_e mode_d;
	logic [1:0] cc_q;
	logic [1:0] cc_d;
	logic prioWr;

	assign idx = regIdx(avs_address);
	// one wait cycle per access keeps read data registered
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
	assign wrTake = avs_write & ack_q & avs_byteenable[0];
	assign prioWr = wrTake && (idx >= `NIPU_IDX_PRIO0) && (idx <= `NIPU_IDX_PRIO3);
	assign avs_readdata = rdata_q;

	// read mux captured one cycle before waitrequest falls; unmapped reads zero
	always_comb begin
		ack_d = (avs_read | avs_write) & ~ack_q;
		rdata_d = rdata_q;
		if (avs_read && !ack_q) begin
			if (idx == `NIPU_IDX_PRIO0) begin
				rdata_d = {24'h000000, prioFlat[7:0]};
			end else if (idx == `NIPU_IDX_PRIO1) begin
				rdata_d = {24'h000000, prioFlat[15:8]};
			end else if (idx == `NIPU_IDX_PRIO2) begin
				rdata_d = {24'h000000, prioFlat[23:16]};
			end else if (idx == `NIPU_IDX_PRIO3) begin
				rdata_d = {24'h000000, prioFlat[31:24]};
			end else if (idx == `NIPU_IDX_STAT) begin
				rdata_d = {28'h0000000, stat_q};
			end else if (idx == `NIPU_IDX_MASK) begin
				rdata_d = {28'h0000000, mask_q};
			end else if (idx == `NIPU_IDX_CTRL) begin
				rdata_d = {31'h00000000, tbie_q};
			end else if (idx == `NIPU_IDX_STATE) begin
				rdata_d = {24'h000000, serviceIndex, mode_q, cc_q};
			end else begin
				rdata_d = 32'h00000000;
			end
		end
	end

	// bus handshake registers
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ack_q <= 1'b0;
			rdata_q <= 32'h00000000;
		end else if (ce) begin
			ack_q <= ack_d;
			rdata_q <= rdata_d;
		end
	end

	// priority storage; the write filter lives inside
	nipu_prio_regs u_prio (
		.clk_sys(clk_sys),
		.rst(rst),
		.ce(ce),
		.wrEn(prioWr),
		.wrIdx(idx[1:0]),
		.wrData(avs_writedata[7:0]),
		.prioFlat(prioFlat),
		.discard(discard)
	);

	//--------------------------------------------------------------------------
	// request gathering
	//--------------------------------------------------------------------------
	logic [1:0] extSel_q;
	logic [NUM_VEC-1:0] reqVec;
	logic [NUM_VEC-1:0] aboveLvl;
	logic [NUM_VEC-1:0] cand;
	logic found;
	logic [3:0] winIdx;
	logic [1:0] winLvl;
	logic lowPower;
	logic halted;

	// option strap sampled while reset is held, so it is stable after release
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			extSel_q <= extSelOption;
		end
	end

	assign halted = (mode_q == MODE_HALT) || (mode_q == MODE_AHALT);
	assign lowPower = (mode_q != MODE_RUN);

	// external vectors take their port group from the strap
	always_comb begin
		reqVec = periphReq;
		reqVec[0] = extSel_q[0] ? extReqC : extReqA;
		reqVec[1] = extSel_q[1] ? extReqC : extReqB;
		for (int i = 0; i < NUM_VEC; i++) begin
			aboveLvl[i] = nipuRank(prioFlat[2*i +: 2]) > nipuRank(cc_q);
		end
		// a pending request stays with its source until acknowledged
		cand = reqVec & periphEnable & aboveLvl;
		if (halted) begin
			cand = cand & `NIPU_WAKE_MASK;
		end
	end

	// fields 0..13 occupy the low 28 bits; bits above are the read-only ones
	nipu_arbiter #(
		.NUM_VEC(NUM_VEC)
	) u_arb (
		.cand(cand),
		.prioFld(prioFlat[2*NUM_VEC-1:0]),
		.found(found),
		.winIdx(winIdx),
		.winLvl(winLvl)
	);

	//--------------------------------------------------------------------------
	// cpu level, mode and service sequencing
	//--------------------------------------------------------------------------
	logic resetPend_q;
	logic resetPend_d;
	logic strobe_q;
	logic strobe_d;
	logic [15:0] vector_q;
	logic [15:0] vector_d;
	logic [3:0] sidx_q;
	logic [3:0] sidx_d;
	logic [NUM_VEC-1:0] ackv_q;
	logic [NUM_VEC-1:0] ackv_d;
	logic evServ;
	logic evWake;
	logic evTrap;

	// reset first, then trap, then a maskable winner, then cpu-side level changes
	always_comb begin
		resetPend_d = resetPend_q;
		cc_d = cc_q;
		mode_d = mode_q;
		strobe_d = 1'b0;
		vector_d = vector_q;
		sidx_d = sidx_q;
		ackv_d = '0;
		evServ = 1'b0;
		evWake = 1'b0;
		evTrap = 1'b0;
		if (resetPend_q) begin
			resetPend_d = 1'b0;
			strobe_d = 1'b1;
			vector_d = `NIPU_VEC_RESET;
			cc_d = `NIPU_LVL3;
			mode_d = MODE_RUN;
		end else if (trapExec && !lowPower) begin
			strobe_d = 1'b1;
			vector_d = `NIPU_VEC_TRAP;
			cc_d = `NIPU_LVL3;
			evTrap = 1'b1;
		end else if (found && (lowPower || instrBoundary)) begin
			// stopped cpu takes the winner at once; running cpu at a boundary
			strobe_d = 1'b1;
			vector_d = vecAddr(winIdx);
			sidx_d = winIdx;
			ackv_d[winIdx] = 1'b1;
			cc_d = winLvl;
			mode_d = MODE_RUN;
			evServ = 1'b1;
			evWake = lowPower;
		end else if (waitExec && !lowPower) begin
			mode_d = MODE_WAIT;
			cc_d = `NIPU_LVL0;
		end else if (haltExec && !lowPower) begin
			mode_d = tbie_q ? MODE_AHALT : MODE_HALT;
			cc_d = `NIPU_LVL0;
		end else if (returnExec && !lowPower) begin
			// level comes back from the stack; a raised field now competes
			cc_d = returnLevel;
		end else if (ccWrite && !lowPower) begin
			cc_d = ccWriteLevel;
		end
	end

	// service registers; reset level 3 and reset vector pending
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			resetPend_q <= 1'b1;
			cc_q <= `NIPU_LVL3;
			mode_q <= MODE_RUN;
			strobe_q <= 1'b0;
			vector_q <= `NIPU_VEC_RESET;
			sidx_q <= 4'h0;
			ackv_q <= '0;
		end else if (ce) begin
			resetPend_q <= resetPend_d;
			cc_q <= cc_d;
			mode_q <= mode_d;
			strobe_q <= strobe_d;
			vector_q <= vector_d;
			sidx_q <= sidx_d;
			ackv_q <= ackv_d;
		end
	end

	assign cpuPrioHigh = cc_q[1];
	assign cpuPrioLow = cc_q[0];
	assign serviceStrobe = strobe_q;
	assign serviceVector = vector_q;
	assign serviceIndex = sidx_q;
	assign serviceAck = ackv_q;
	// wait stops only the cpu; peripheral requests are still gathered
	assign cpuStopped = lowPower;
	assign haltActive = (mode_q == MODE_HALT);
	assign activeHaltActive = (mode_q == MODE_AHALT);

	//--------------------------------------------------------------------------
	// software registers and interrupt output
	//--------------------------------------------------------------------------

	// status bits are write-one-to-clear; a same-cycle event keeps its bit
	always_comb begin
		logic [`NIPU_ST_W-1:0] setv;
		setv = '0;
		setv[`NIPU_ST_SERV] = evServ;
		setv[`NIPU_ST_WAKE] = evWake;
		setv[`NIPU_ST_TRAP] = evTrap;
		setv[`NIPU_ST_DISC] = discard & prioWr;
		stat_d = stat_q;
		mask_d = mask_q;
		tbie_d = tbie_q;
		if (wrTake && idx == `NIPU_IDX_STAT) begin
			stat_d = stat_q & ~avs_writedata[`NIPU_ST_W-1:0];
		end else if (wrTake && idx == `NIPU_IDX_MASK) begin
			mask_d = avs_writedata[`NIPU_ST_W-1:0];
		end else if (wrTake && idx == `NIPU_IDX_CTRL) begin
			tbie_d = avs_writedata[`NIPU_CTRL_TBIE];
		end
		stat_d = stat_d | setv;
	end

	// software registers storage
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			stat_q <= '0;
			mask_q <= '0;
			tbie_q <= 1'b0;
		end else if (ce) begin
			stat_q <= stat_d;
			mask_q <= mask_d;
			tbie_q <= tbie_d;
		end
	end

	assign irq = |(stat_q & mask_q);
endmodule : nipu_top

`default_nettype wire

/* File: nipu_cfg.svh */
// constants of the nested interrupt priority unit: offsets, resets, vector map
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
`ifndef NIPU_CFG_SVH
`define NIPU_CFG_SVH

// register indices; byte address is four times the index
`define NIPU_IDX_PRIO0 6'h1c
`define NIPU_IDX_PRIO1 6'h1d
`define NIPU_IDX_PRIO2 6'h1e
`define NIPU_IDX_PRIO3 6'h1f
`define NIPU_IDX_STAT 6'h20
`define NIPU_IDX_MASK 6'h21
`define NIPU_IDX_CTRL 6'h22
`define NIPU_IDX_STATE 6'h23

// priority register values
`define NIPU_PRIO_RST 8'hff
`define NIPU_PRIO3_RO 8'hf0
`define NIPU_LVL0 2'b10
`define NIPU_LVL1 2'b01
`define NIPU_LVL2 2'b00
`define NIPU_LVL3 2'b11

// vector addresses
`define NIPU_VEC_RESET 16'hfffe
`define NIPU_VEC_TRAP 16'hfffc
`define NIPU_VEC_BASE 16'hfffa

// vectors able to leave halt: 0, 1, 3, 5
`define NIPU_WAKE_MASK 14'h002b

// status, mask and control bits
`define NIPU_ST_W 4
`define NIPU_ST_SERV 0
`define NIPU_ST_WAKE 1
`define NIPU_ST_TRAP 2
`define NIPU_ST_DISC 3
`define NIPU_CTRL_TBIE 0

`endif

/* File: nipu_pkg.sv */
// types and shared functions of the nested interrupt priority unit
`include "nipu_cfg.svh"

package nipu_pkg;
	// cpu activity mode
	typedef enum logic [1:0] {
		MODE_RUN,
		MODE_WAIT,
		MODE_HALT,
		MODE_AHALT
	} nipu_mode_e;

	typedef logic [1:0] nipu_lvl_t;

	// ordinal of a priority encoding, 0 lowest to 3 highest
	function automatic logic [1:0] nipuRank(input nipu_lvl_t lvl);
		case (lvl)
			`NIPU_LVL0: nipuRank = 2'h0;
			`NIPU_LVL1: nipuRank = 2'h1;
			`NIPU_LVL2: nipuRank = 2'h2;
			default: nipuRank = 2'h3;
		endcase
	endfunction : nipuRank
endpackage : nipu_pkg

/* File: nipu_prio_regs.sv */
// four software priority registers with the level-0 write filter
`timescale 1ns/100ps
`default_nettype none

module nipu_prio_regs
	import nipu_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	// write port
	input wire logic wrEn,
	input wire logic [1:0] wrIdx,
	input wire logic [7:0] wrData,
	// contents and events
	output logic [31:0] prioFlat,
	output logic discard
);
	logic [7:0] prio_q [4];
	logic [7:0] prio_d [4];

	// per field: a level-0 pattern keeps the old field
	always_comb begin
		discard = 1'b0;
		for (int r = 0; r < 4; r++) begin
			prio_d[r] = prio_q[r];
		end
		if (wrEn) begin
			for (int f = 0; f < 4; f++) begin
				if (wrData[2*f +: 2] != `NIPU_LVL0) begin
					prio_d[wrIdx][2*f +: 2] = wrData[2*f +: 2];
				end else begin
					discard = 1'b1;
				end
			end
		end
		prio_d[3] = prio_d[3] | `NIPU_PRIO3_RO;
	end

	// storage
	always_ff @(posedge clk_sys) begin
		for (int r = 0; r < 4; r++) begin
			if (rst) begin
				prio_q[r] <= `NIPU_PRIO_RST;
			end else if (ce) begin
				prio_q[r] <= prio_d[r];
			end
		end
	end

	assign prioFlat = {prio_q[3], prio_q[2], prio_q[1], prio_q[0]};
endmodule : nipu_prio_regs

`default_nettype wire

/* File: nipu_arbiter.sv */
// picks the serviced vector among candidates by software then hardware order
`timescale 1ns/100ps
`default_nettype none

module nipu_arbiter
	import nipu_pkg::*;
#(
	parameter int NUM_VEC = 14
) (
	// candidates and their fields
	input wire logic [NUM_VEC-1:0] cand,
	input wire logic [2*NUM_VEC-1:0] prioFld,
	// winner
	output logic found,
	output logic [3:0] winIdx,
	output logic [1:0] winLvl
);
	logic [1:0] bestRank;

	// scan downward so an equal rank at a lower index takes over
	always_comb begin
		found = 1'b0;
		winIdx = 4'h0;
		winLvl = `NIPU_LVL0;
		bestRank = 2'h0;
		for (int i = NUM_VEC - 1; i >= 0; i--) begin
			if (cand[i] && (!found || nipuRank(prioFld[2*i +: 2]) >= bestRank)) begin
				found = 1'b1;
				winIdx = 4'(i);
				winLvl = prioFld[2*i +: 2];
				bestRank = nipuRank(prioFld[2*i +: 2]);
			end
		end
	end
endmodule : nipu_arbiter

`default_nettype wire

/* File: nipu_monitor.sv */
// port checker of the nested interrupt priority unit
`timescale 1ns/100ps
`default_nettype none
`include "nipu_cfg.svh"

module nipu_monitor
	import nipu_pkg::*;
#(
	parameter int NUM_VEC = 14
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	// register bus
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// cpu events
	input wire logic instrBoundary,
	input wire logic trapExec,
	input wire logic waitExec,
	input wire logic haltExec,
	// cpu answers
	input wire logic cpuPrioHigh,
	input wire logic cpuPrioLow,
	input wire logic serviceStrobe,
	input wire logic [15:0] serviceVector,
	input wire logic [3:0] serviceIndex,
	input wire logic [NUM_VEC-1:0] serviceAck,
	input wire logic cpuStopped,
	input wire logic haltActive,
	input wire logic activeHaltActive
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic [1:0] cc;
	logic anyAck;
	logic idle;
	// idle: no boundary and running, so no maskable candidate can compete
	assign cc = {cpuPrioHigh, cpuPrioLow};
	assign anyAck = |serviceAck;
	assign idle = ce && !cpuStopped && !trapExec && !instrBoundary;

	a_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest && ce |=>
		!avs_waitrequest) else $error("bus wait not one cycle");
	a_upper_zero: assert property (avs_read && !avs_waitrequest |->
		avs_readdata[31:8] == 24'h0) else $error("upper read bits set");
	a_reset_entry: assert property ($fell(rst) && ce |=>
		serviceStrobe && serviceVector == `NIPU_VEC_RESET && cc == 2'h3) else $error("reset entry");
	a_trap_entry: assert property (trapExec && ce && !cpuStopped |=>
		serviceStrobe && serviceVector == `NIPU_VEC_TRAP && cc == 2'h3) else $error("trap entry");
	a_vector_addr: assert property (anyAck |->
		serviceVector == 16'hfffa - {11'h0, serviceIndex, 1'h0}) else $error("vector address");
	a_ack_onehot: assert property (anyAck |->
		serviceStrobe && serviceAck == (NUM_VEC'(1) << serviceIndex)) else $error("ack not one-hot");
	a_level_rises: assert property (anyAck |->
		nipuRank(cc) > nipuRank($past(cc))) else $error("service not above cpu level");
	a_no_level0: assert property (serviceStrobe |-> cc != `NIPU_LVL0)
		else $error("level 0 loaded on service");
	a_halt_wake: assert property (anyAck && ($past(haltActive) || $past(activeHaltActive)) |->
		(serviceAck & ~`NIPU_WAKE_MASK) == '0) else $error("non-wake vector left halt");
	a_wait_entry: assert property (waitExec && idle |=>
		cpuStopped && cc == `NIPU_LVL0) else $error("wait entry");
	a_halt_entry: assert property (haltExec && !waitExec && idle |=>
		(haltActive ^ activeHaltActive) && cc == `NIPU_LVL0) else $error("halt entry");
endmodule : nipu_monitor

bind nipu_top nipu_monitor #(.NUM_VEC(NUM_VEC)) mon_u (.clk_sys, .rst, .ce, .avs_read,
	.avs_write, .avs_readdata, .avs_waitrequest, .instrBoundary, .trapExec, .waitExec,
	.haltExec, .cpuPrioHigh, .cpuPrioLow, .serviceStrobe, .serviceVector, .serviceIndex,
	.serviceAck, .cpuStopped, .haltActive, .activeHaltActive);
`default_nettype wire

/* File: nipu_src_model.sv */
// behavioural request sources: levels held until acknowledged
`timescale 1ns/100ps
`default_nettype none

module nipu_src_model #(
	parameter int NUM_VEC = 14
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// raise pulses from the bench, acknowledges from the unit
	input wire logic [NUM_VEC-1:0] raise,
	input wire logic [NUM_VEC-1:0] serviceAck,
	// request levels
	output logic [NUM_VEC-1:0] periphReq
);
	logic [NUM_VEC-1:0] req_d;
	logic [NUM_VEC-1:0] req_q;
	// a flag stays up until serviced, so an unserved request pends
	always_comb begin
		req_d = (req_q | raise) & ~serviceAck;
	end
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			req_q <= '0;
		end else begin
			req_q <= req_d;
		end
	end
	assign periphReq = req_q;
endmodule : nipu_src_model
`default_nettype wire

/* File: nipu_tb_top.sv */
// self-checking bench of the nested interrupt priority unit
`timescale 1ns/100ps
`default_nettype none

module nipu_tb_top;
	logic clk_sys, rst, avs_read, avs_write, avs_waitrequest, instrBoundary, extReqA, irq;
	logic cpuPrioHigh, cpuPrioLow, serviceStrobe, cpuStopped, haltActive, activeHaltActive;
	logic [7:0] avs_address, q;
	logic [3:0] avs_byteenable, serviceIndex;
	logic [31:0] avs_writedata, avs_readdata;
	logic [4:0] evt;
	logic [1:0] lvl, extSel;
	logic [13:0] raise, periphReq, serviceAck, en;
	logic extReqC;
	logic [15:0] serviceVector;
	int num_errors = 0;
	int check_count = 0;
	// rows: noBe, write, address, data, expected read
	logic [31:0] rows [11] = '{32'h00_70_00_ff, 32'h00_74_00_ff, 32'h00_78_00_ff,
		32'h00_7c_00_ff, 32'h01_70_cf_cf, 32'h01_70_64_44, 32'h03_70_00_44,
		32'h01_7c_00_f0, 32'h01_78_55_55, 32'h01_74_aa_ff, 32'h01_a0_5a_00};
	// expected service order: level, vector
	logic [17:0] ord [4] = '{18'h0ffe2, 18'h1fff4, 18'h1fff2, 18'h1ffea};

	nipu_top dut_u (.clk_sys, .rst, .ce(1'h1), .avs_address, .avs_read, .avs_write,
		.avs_byteenable, .avs_writedata, .avs_readdata, .avs_waitrequest, .extReqA,
		.extReqB(1'h0), .extReqC, .extSelOption(extSel), .periphReq,
		.periphEnable(en), .instrBoundary, .trapExec(evt[0]), .waitExec(evt[1]),
		.haltExec(evt[2]), .returnExec(evt[3]), .returnLevel(lvl), .ccWrite(evt[4]),
		.ccWriteLevel(lvl), .cpuPrioHigh, .cpuPrioLow, .serviceStrobe, .serviceVector,
		.serviceIndex, .serviceAck, .cpuStopped, .haltActive, .activeHaltActive, .irq);
	nipu_src_model src_u (.clk_sys, .rst, .raise, .serviceAck, .periphReq);

	//--------------------------------------------------
	// tasks
	//--------------------------------------------------
	task automatic chk(input string n, input logic [15:0] e, g);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask : chk
	// request held until waitrequest is sampled low
	// no cycle count is assumed; only the watchdog ends a wait that never comes
	task automatic bus(input logic w, input logic [7:0] a, d, output logic [7:0] r);
		@(posedge clk_sys);
		avs_write <= w;
		avs_read <= !w;
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		do begin
			@(posedge clk_sys);
		end while (avs_waitrequest !== 1'h0);
		r = avs_readdata[7:0];
		avs_write <= 1'h0;
		avs_read <= 1'h0;
	endtask : bus
	task automatic rd(input logic [7:0] a, e);
		logic [7:0] r;
		bus(1'h0, a, 8'h0, r);
		chk("register", {8'h0, e}, {8'h0, r});
	endtask : rd
	// one-cycle cpu event: 0 trap, 1 wait, 2 halt, 3 return, 4 level write
	task automatic cpu(input int k, input logic [1:0] l);
		@(posedge clk_sys);
		evt <= 5'h1 << k;
		lvl <= l;
		@(posedge clk_sys);
		evt <= 5'h0;
	endtask : cpu
	task automatic up(input logic [13:0] v);
		@(posedge clk_sys);
		raise <= v;
		@(posedge clk_sys);
		raise <= '0;
	endtask : up
	// wait for the next service, bounded by the watchdog, then its vector and level
	task automatic svc(input logic [15:0] v, input logic [1:0] c);
		do begin
			@(posedge clk_sys);
		end while (serviceStrobe !== 1'h1);
		chk("vector", v, serviceVector);
		chk("level", {14'h0, c}, {14'h0, cpuPrioHigh, cpuPrioLow});
	endtask : svc
	task automatic conclude;
		if (num_errors == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : conclude

	//--------------------------------------------------
	// clock, watchdog, sequence
	//--------------------------------------------------
	initial begin
		clk_sys = 1'h0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (3000) @(posedge clk_sys);
		num_errors++;
		conclude();
	end
	initial begin
		{rst, avs_read, avs_write, instrBoundary, extReqA} = 5'h10;
		{avs_address, avs_writedata, evt, lvl, raise, extSel, extReqC} = '0;
		en = 14'h3fff;
		avs_byteenable = 4'h1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'h0;
		svc(16'hfffe, 2'h3);
		for (int i = 0; i < 11; i++) begin
			avs_byteenable <= {3'h0, !rows[i][25]};
			if (rows[i][24]) bus(1'h1, rows[i][23:16], rows[i][15:8], q);
			rd(rows[i][23:16], rows[i][7:0]);
		end
		// a field at level 1 served from main level
		bus(1'h1, 8'h74, 8'hfd, q);
		cpu(4, 2'h2);
		instrBoundary <= 1'h1;
		up(14'h0010);
		svc(16'hfff2, 2'h1);
		// a raised field on the running vector with a fresh request re-enters it
		up(14'h0010);
		bus(1'h1, 8'h74, 8'hfc, q);
		svc(16'hfff2, 2'h0);
		bus(1'h1, 8'h74, 8'hfd, q);
		cpu(3, 2'h2);
		// four pending at once: software level first, then fixed order
		up(14'h1118);
		for (int i = 0; i < 4; i++) begin
			svc(ord[i][15:0], ord[i][17:16]);
			cpu(3, 2'h2);
		end
		instrBoundary <= 1'h0;
		cpu(0, 2'h0);
		svc(16'hfffc, 2'h3);
		cpu(1, 2'h0);
		rd(8'h8c, 8'h86);
		chk("stopped", 16'h1, {15'h0, cpuStopped});
		up(14'h0040);
		svc(16'hffee, 2'h3);
		// halt with time base enable set; a non-wake request must wait
		bus(1'h1, 8'h88, 8'h01, q);
		cpu(2, 2'h0);
		up(14'h0010);
		rd(8'h8c, 8'h6e);
		chk("active halt", 16'h1, {15'h0, activeHaltActive});
		extReqA <= 1'h1;
		svc(16'hfffa, 2'h0);
		extReqA <= 1'h0;
		instrBoundary <= 1'h1;
		cpu(3, 2'h2);
		svc(16'hfff2, 2'h1);
		// status sticky bits, mask and clear
		rd(8'h80, 8'h0f);
		chk("irq", 16'h0, {15'h0, irq});
		bus(1'h1, 8'h84, 8'h02, q);
		@(posedge clk_sys);
		chk("irq", 16'h1, {15'h0, irq});
		bus(1'h1, 8'h80, 8'h0f, q);
		@(posedge clk_sys);
		chk("irq", 16'h0, {15'h0, irq});
		rd(8'h80, 8'h00);
		// mid-run reset moves vector 0 to the third group; plain halt, disabled source
		extSel <= 2'h1;
		instrBoundary <= 1'h0;
		rst <= 1'h1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'h0;
		svc(16'hfffe, 2'h3);
		cpu(2, 2'h0);
		en <= 14'h3ffe;
		extReqC <= 1'h1;
		rd(8'h8c, 8'h0a);
		chk("halt", 16'h1, {15'h0, haltActive});
		rd(8'h70, 8'hff);
		en <= 14'h3fff;
		svc(16'hfffa, 2'h3);
		extReqC <= 1'h0;
		conclude();
	end
endmodule : nipu_tb_top
`default_nettype wire
